// *** logic/tmr8_pkg.sv ***
package tmr8_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses on the APB bus.
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_COUNT = 8'h00;
  localparam logic [7:0] ADDR_CMP_A = 8'h04;
  localparam logic [7:0] ADDR_CMP_B = 8'h08;
  localparam logic [7:0] ADDR_CTRL1 = 8'h0c;
  localparam logic [7:0] ADDR_CTRL2 = 8'h10;
  localparam logic [7:0] ADDR_FLAG = 8'h14;
  localparam logic [7:0] ADDR_MASK = 8'h18;

  // ----------------------------------------------------------------
  // Field positions, reset values and counter landmarks.
  // ----------------------------------------------------------------
  localparam int FLAG_OVF = 0;
  localparam int FLAG_MA = 1;
  localparam int FLAG_MB = 2;
  localparam int WGM_HI_BIT = 3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;

  // ----------------------------------------------------------------
  // Counting sequence codes of the three wave mode bits.
  // ----------------------------------------------------------------
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_PC_MAX = 3'h1;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_PC_A = 3'h5;
  localparam logic [2:0] WGM_FAST_A = 3'h7;

  // ----------------------------------------------------------------
  // Clock select codes and prescaler tap masks.
  // ----------------------------------------------------------------
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [9:0] TAP_DIV8 = 10'h007;
  localparam logic [9:0] TAP_DIV64 = 10'h03f;
  localparam logic [9:0] TAP_DIV256 = 10'h0ff;
  localparam logic [9:0] TAP_DIV1024 = 10'h3ff;

  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } tmr8_dir_e;

  // Pulse-width modes have odd mode codes; they buffer the compare values.
  function automatic logic is_pwm(input logic [2:0] wgm);
    return wgm[0];
  endfunction

  // Top is compare A when the high mode bit is set or in clear mode, else the fixed maximum.
  function automatic logic [7:0] top_of(input logic [2:0] wgm, input logic [7:0] cmp_a);
    return (wgm[2] || wgm == WGM_CTC) ? cmp_a : CNT_MAX;
  endfunction

endpackage

// *** logic/tmr8_clksel.sv ***
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Timer tick source: prescaler taps or a synchronised external pin.
// ------------------------------------------------------------------
module tmr8_clksel (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] cs,
  input wire logic ext_pin,
  output logic tick
);
  import tmr8_pkg::*;

  typedef struct packed {
    logic [9:0] pre;
    logic sync1;
    logic sync2;
    logic last;
  } tmr8_sel_s;

  tmr8_sel_s st_r;
  tmr8_sel_s st_nxt;
  logic rise;
  logic fall;

  // Free-running prescaler; the pin passes two flops before the edge detector.
  always_comb begin
    st_nxt = st_r;
    st_nxt.pre = 10'(st_r.pre + 10'h001);
    st_nxt.sync1 = ext_pin;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.last = st_r.sync2;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Only the second sync stage and its delayed copy feed the edge logic.
  assign rise = st_r.sync2 & ~st_r.last;
  assign fall = ~st_r.sync2 & st_r.last;

  // A zero select gives no tick at all, so the counter stands still.
  always_comb begin
    case (cs)
      CS_STOP: tick = 1'b0;
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = (st_r.pre & TAP_DIV8) == TAP_DIV8;
      CS_DIV64: tick = (st_r.pre & TAP_DIV64) == TAP_DIV64;
      CS_DIV256: tick = (st_r.pre & TAP_DIV256) == TAP_DIV256;
      CS_DIV1024: tick = st_r.pre == TAP_DIV1024;
      CS_EXT_FALL: tick = fall;
      CS_EXT_RISE: tick = rise;
      default: tick = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// *** logic/tmr8_counter.sv ***
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Count and both compare values are 8-bit, readable and writable registers.
// - Bottom is reached when the count becomes zero; flag it internally.
// - Maximum is reached when the count becomes 255.
// - Top is 255 or compare value A, depending on mode.
// - Three-bit clock select picks prescaler tap or external pin edge.
// - Clock select zero gives no tick; counter stays stopped.
// - Each tick clears, increments or decrements the count per mode and direction.
// - Software may read and write the count at any time.
// - A count write beats a simultaneous clear or count step.
// - Three mode bits: two in first control, one in second control register.
// - Overflow flag set at mode-dependent points; usable as interrupt source.
// - Overflow, match A, match B flags in one register, each individually masked.
// - Both compare values are compared with the count every cycle.
// - A match sets the matching compare flag.
// - Each compare value has a double buffer.
// - A mode clears the count on compare match.
// - Buffer bypassed in normal, clear and reserved modes; loaded at top in pulse-width modes.
// - Compare flag set on the tick after match; cleared by ack or write-one.
// - A count write blocks compare matches during the next tick.
// - Normal mode counts up, wraps 255 to zero, sets overflow at zero.
module tmr8_counter (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_COUNT_PIN,
  input wire logic ACK_OVF,
  input wire logic ACK_MATCH_A,
  input wire logic ACK_MATCH_B,
  output logic IRQ_OVF,
  output logic IRQ_MATCH_A,
  output logic IRQ_MATCH_B,
  output logic MATCH_A,
  output logic MATCH_B,
  output logic TOP_HIT,
  output logic BOTTOM_HIT,
  output logic MAX_HIT,
  output logic COUNT_DOWN,
  output logic TIMER_TICK
);
  import tmr8_pkg::*;

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] ocr_a;
    logic [7:0] ocr_b;
    logic [7:0] buf_a;
    logic [7:0] buf_b;
    logic [1:0] wgm_lo;
    logic [2:0] cs;
    logic wgm_hi;
    logic [2:0] flags;
    logic [2:0] mask;
    tmr8_dir_e dir;
    logic block;
    logic [31:0] rdata;
  } tmr8_core_s;

  tmr8_core_s st_r;
  tmr8_core_s st_nxt;
  logic tick;
  logic [2:0] wgm;
  logic [7:0] top_val;
  logic match_a;
  logic match_b;
  logic at_top;
  logic at_bottom;
  logic wr_en;
  logic wr_cnt;
  logic addr_ok;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  logic upd_buf;

  // ----------------------------------------------------------------
  // Tick source.
  // ----------------------------------------------------------------
  tmr8_clksel u_clksel (
    .clk(CLOCK),
    .rst(SYS_RST),
    .cs(st_r.cs),
    .ext_pin(EXT_COUNT_PIN),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Decode and comparators.
  // ----------------------------------------------------------------

  // Mode bits are split over the two control registers.
  assign wgm = {st_r.wgm_hi, st_r.wgm_lo};
  assign top_val = top_of(wgm, st_r.ocr_a);
  // The comparators run every cycle, not only on ticks.
  assign match_a = st_r.cnt == st_r.ocr_a;
  assign match_b = st_r.cnt == st_r.ocr_b;
  assign at_top = st_r.cnt == top_val;
  assign at_bottom = st_r.cnt == CNT_BOTTOM;
  assign wr_en = PSEL & PENABLE & PWRITE;
  assign wr_cnt = wr_en && PADDR == ADDR_COUNT;

  // Any of the seven words is mapped; all else answers with an error.
  always_comb begin
    case (PADDR)
      ADDR_COUNT, ADDR_CMP_A, ADDR_CMP_B, ADDR_CTRL1: addr_ok = 1'b1;
      ADDR_CTRL2, ADDR_FLAG, ADDR_MASK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    flag_set = 3'h0;
    flag_clr = {ACK_MATCH_B, ACK_MATCH_A, ACK_OVF};
    upd_buf = 1'b0;
    if (tick) begin
      // The block covers exactly one tick after a count write.
      st_nxt.block = 1'b0;
      flag_set[FLAG_MA] = match_a & ~st_r.block;
      flag_set[FLAG_MB] = match_b & ~st_r.block;
      case (wgm)
        WGM_NORMAL: begin
          st_nxt.cnt = 8'(st_r.cnt + 8'h01);
          flag_set[FLAG_OVF] = st_r.cnt == CNT_MAX;
        end
        WGM_CTC: begin
          if (at_top) begin
            st_nxt.cnt = CNT_BOTTOM;
          end else begin
            st_nxt.cnt = 8'(st_r.cnt + 8'h01);
          end
          flag_set[FLAG_OVF] = st_r.cnt == CNT_MAX;
        end
        WGM_FAST_MAX, WGM_FAST_A: begin
          if (at_top) begin
            st_nxt.cnt = CNT_BOTTOM;
            flag_set[FLAG_OVF] = 1'b1;
            upd_buf = 1'b1;
          end else begin
            st_nxt.cnt = 8'(st_r.cnt + 8'h01);
          end
        end
        WGM_PC_MAX, WGM_PC_A: begin
          if (st_r.dir == DIR_UP) begin
            if (at_top) begin
              st_nxt.dir = DIR_DOWN;
              st_nxt.cnt = 8'(st_r.cnt - 8'h01);
              upd_buf = 1'b1;
            end else begin
              st_nxt.cnt = 8'(st_r.cnt + 8'h01);
            end
          end else begin
            if (at_bottom) begin
              st_nxt.dir = DIR_UP;
              st_nxt.cnt = 8'(st_r.cnt + 8'h01);
              flag_set[FLAG_OVF] = 1'b1;
            end else begin
              st_nxt.cnt = 8'(st_r.cnt - 8'h01);
            end
          end
        end
        default: begin
          // Reserved codes count upward but raise no overflow flag.
          st_nxt.cnt = 8'(st_r.cnt + 8'h01);
        end
      endcase
      if (wgm == WGM_NORMAL || wgm == WGM_CTC) begin
        st_nxt.dir = DIR_UP;
      end
    end
    // Buffered compare values move to the comparators at top.
    if (upd_buf) begin
      st_nxt.ocr_a = st_r.buf_a;
      st_nxt.ocr_b = st_r.buf_b;
    end
    // Bus writes come last so they override the counting above.
    if (wr_en) begin
      case (PADDR)
        ADDR_COUNT: begin
          st_nxt.cnt = PWDATA[7:0];
          st_nxt.block = 1'b1;
        end
        ADDR_CMP_A: begin
          st_nxt.buf_a = PWDATA[7:0];
          if (!is_pwm(wgm)) begin
            st_nxt.ocr_a = PWDATA[7:0];
          end
        end
        ADDR_CMP_B: begin
          st_nxt.buf_b = PWDATA[7:0];
          if (!is_pwm(wgm)) begin
            st_nxt.ocr_b = PWDATA[7:0];
          end
        end
        ADDR_CTRL1: st_nxt.wgm_lo = PWDATA[1:0];
        ADDR_CTRL2: begin
          st_nxt.cs = PWDATA[2:0];
          st_nxt.wgm_hi = PWDATA[WGM_HI_BIT];
        end
        ADDR_FLAG: flag_clr = flag_clr | PWDATA[2:0];
        ADDR_MASK: st_nxt.mask = PWDATA[2:0];
        default: begin
        end
      endcase
    end
    // A hardware set in the same cycle as a clear keeps the flag.
    st_nxt.flags = (st_r.flags & ~flag_clr) | flag_set;
    // Read data is captured in the setup phase, ready for the access phase.
    if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        ADDR_COUNT: st_nxt.rdata = {24'h000000, st_r.cnt};
        ADDR_CMP_A: st_nxt.rdata = {24'h000000, st_r.buf_a};
        ADDR_CMP_B: st_nxt.rdata = {24'h000000, st_r.buf_b};
        ADDR_CTRL1: st_nxt.rdata = {30'h0, st_r.wgm_lo};
        ADDR_CTRL2: st_nxt.rdata = {28'h0000000, st_r.wgm_hi, st_r.cs};
        ADDR_FLAG: st_nxt.rdata = {29'h0, st_r.flags};
        ADDR_MASK: st_nxt.rdata = {29'h0, st_r.mask};
        default: st_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  // Everything clears on reset except the direction, which starts up; with select zero the timer is stopped.
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_r <= '0;
      st_r.dir <= DIR_UP;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------

  // The slave never waits, so the access phase always ends at once.
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_ok;
  assign PRDATA = st_r.rdata;
  assign IRQ_OVF = st_r.flags[FLAG_OVF] & st_r.mask[FLAG_OVF];
  assign IRQ_MATCH_A = st_r.flags[FLAG_MA] & st_r.mask[FLAG_MA];
  assign IRQ_MATCH_B = st_r.flags[FLAG_MB] & st_r.mask[FLAG_MB];
  assign MATCH_A = match_a;
  assign MATCH_B = match_b;
  assign TOP_HIT = at_top;
  assign BOTTOM_HIT = at_bottom;
  assign MAX_HIT = st_r.cnt == CNT_MAX;
  assign COUNT_DOWN = st_r.dir == DIR_DOWN;
  assign TIMER_TICK = tick;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  sequence s_cnt_write;
    wr_cnt;
  endsequence

  // The first tick after a count write, however late it comes, with a live match.
  sequence s_blocked_tick;
    tick && st_r.block && match_a && !st_r.flags[FLAG_MA];
  endsequence

  a_write_wins: assert property (
    s_cnt_write |=> st_r.cnt == $past(PWDATA[7:0]))
    else $error("count write did not override counting");

  a_block_match: assert property (
    s_blocked_tick |=> !st_r.flags[FLAG_MA])
    else $error("match after count write was not blocked");

  a_stop_hold: assert property (
    (st_r.cs == CS_STOP && !wr_cnt) |=> $stable(st_r.cnt))
    else $error("count moved with no clock selected");

  a_normal_wrap: assert property (
    (tick && wgm == WGM_NORMAL && st_r.cnt == CNT_MAX && !wr_cnt)
      |=> (st_r.cnt == CNT_BOTTOM && st_r.flags[FLAG_OVF]))
    else $error("normal wrap or overflow flag wrong");

  a_match_flag: assert property (
    (tick && match_a && !st_r.block) |=> st_r.flags[FLAG_MA])
    else $error("compare A match did not set its flag");

  a_ctc_clear: assert property (
    (tick && wgm == WGM_CTC && at_top && !wr_cnt) |=> st_r.cnt == CNT_BOTTOM)
    else $error("clear on match did not clear the count");

  a_direct_cmp: assert property (
    (wr_en && PADDR == ADDR_CMP_A && !is_pwm(wgm))
      |=> st_r.ocr_a == $past(PWDATA[7:0]))
    else $error("unbuffered compare write not direct");

  a_flag_w1c: assert property (
    (wr_en && PADDR == ADDR_FLAG && PWDATA[FLAG_OVF] && !flag_set[FLAG_OVF])
      |=> !st_r.flags[FLAG_OVF])
    else $error("write one did not clear overflow flag");

  a_pc_turn: assert property (
    (tick && wgm[1:0] == 2'b01 && st_r.dir == DIR_UP && at_top && !wr_cnt)
      |=> (st_r.dir == DIR_DOWN && st_r.cnt == 8'($past(st_r.cnt) - 8'h01)))
    else $error("phase correct turn at top wrong");

endmodule
`default_nettype wire

// *** bench/tmr8_counter_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tmr8_counter_tb;
  import tmr8_pkg::*;

  // ------------------------------------------------------------
  // Stimulus, observation and scoreboard state.
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic ext_pin = 1'b0;
  logic ack_ovf = 1'b0;
  logic ack_ma = 1'b0;
  logic ack_mb = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, irq_ovf, irq_ma, irq_mb, match_a, match_b;
  logic top_hit, bottom_hit, max_hit, count_down, tick;
  logic saw_down = 1'b0;
  logic [64:0] mon_e;
  logic [64:0] exp_q[$];
  logic [7:0] ra[6] = '{ADDR_CMP_A, ADDR_CMP_B, ADDR_COUNT, ADDR_CTRL1, ADDR_CTRL2, ADDR_MASK};
  logic [31:0] rm[6] = '{32'hff, 32'hff, 32'hff, 32'h3, 32'hf, 32'h7};
  logic [31:0] wd;
  int divs[4] = '{8, 64, 256, 1024};
  int fails = 0;
  int n_tests = 0;
  int seed = 32'he9801286;

  // 50 MHz clock.
  always #10 clk = ~clk;

  tmr8_counter dut (
    .CLOCK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EXT_COUNT_PIN(ext_pin), .ACK_OVF(ack_ovf),
    .ACK_MATCH_A(ack_ma), .ACK_MATCH_B(ack_mb), .IRQ_OVF(irq_ovf),
    .IRQ_MATCH_A(irq_ma), .IRQ_MATCH_B(irq_mb), .MATCH_A(match_a),
    .MATCH_B(match_b), .TOP_HIT(top_hit), .BOTTOM_HIT(bottom_hit),
    .MAX_HIT(max_hit), .COUNT_DOWN(count_down), .TIMER_TICK(tick)
  );

  // ------------------------------------------------------------
  // Comparison, verdict and bus tasks.
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (fails == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // The expectation is queued first; the monitor compares the masked read data.
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic err);
    exp_q.push_back({err, m, e});
    apb(1'b0, a, 32'h0);
  endtask

  // Runs the timer with the given second control value for a span of cycles.
  task automatic run(input logic [2:0] c2, input int ncyc);
    wr(ADDR_CTRL2, {29'h0, c2});
    repeat (ncyc) @(posedge clk);
    wr(ADDR_CTRL2, 32'h0);
  endtask

  // ------------------------------------------------------------
  // Monitor: every completed read takes the oldest expectation.
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      chk(prdata & mon_e[63:32], mon_e[31:0]);
      chk({31'h0, pslverr}, {31'h0, mon_e[64]});
    end
    if (count_down === 1'b1) saw_down <= 1'b1;
  end

  // A hang must not pass silently.
  initial begin
    #(20 * 60000);
    fails++;
    final_report();
  end

  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'hffffffff, 32'h0, 1'b0);
    rd(8'h1c, 32'hffffffff, 32'h0, 1'b1);
    @(negedge clk);
    chk({28'h0, tick, match_b, match_a, bottom_hit}, 32'h7);
    // Random values, with the clock select kept at zero so the count holds.
    for (int i = 0; i < 6; i++) begin
      wd = $random(seed);
      if (i == 4) wd = wd & 32'h8;
      wr(ra[i], wd);
      rd(ra[i], 32'hffffffff, wd & rm[i], 1'b0);
    end
    wr(ADDR_CTRL1, 32'h0);
    wr(ADDR_CTRL2, 32'h0);
    wr(ADDR_MASK, 32'h7);
    wr(ADDR_COUNT, 32'h33);
    repeat (30) @(posedge clk);
    rd(ADDR_COUNT, 32'hffffffff, 32'h33, 1'b0);
    wr(ADDR_COUNT, 32'hff);
    @(negedge clk);
    chk({30'h0, max_hit, top_hit}, 32'h3);
    // Wrap from the maximum sets the overflow flag only.
    wr(ADDR_CMP_A, 32'h80);
    wr(ADDR_CMP_B, 32'h80);
    wr(ADDR_FLAG, 32'h7);
    wr(ADDR_COUNT, 32'hfe);
    run(CS_DIV1, 10);
    rd(ADDR_FLAG, 32'h7, 32'h1, 1'b0);
    @(negedge clk);
    chk({31'h0, irq_ovf}, 32'h1);
    @(posedge clk);
    ack_ovf <= 1'b1;
    @(posedge clk);
    ack_ovf <= 1'b0;
    rd(ADDR_FLAG, 32'h1, 32'h0, 1'b0);
    // A count write equal to compare A hides that match on the next tick.
    wr(ADDR_CMP_A, 32'h10);
    wr(ADDR_CMP_B, 32'h14);
    wr(ADDR_COUNT, 32'h10);
    run(CS_DIV1, 10);
    rd(ADDR_FLAG, 32'h6, 32'h4, 1'b0);
    @(negedge clk);
    chk({30'h0, irq_mb, irq_ma}, 32'h2);
    wr(ADDR_COUNT, 32'h0e);
    run(CS_DIV1, 10);
    rd(ADDR_FLAG, 32'h6, 32'h6, 1'b0);
    ack_ma <= 1'b1;
    @(posedge clk);
    ack_ma <= 1'b0;
    rd(ADDR_FLAG, 32'h6, 32'h4, 1'b0);
    wr(ADDR_MASK, 32'h3);
    @(negedge clk);
    chk({31'h0, irq_mb}, 32'h0);
    wr(ADDR_FLAG, 32'h4);
    rd(ADDR_FLAG, 32'h6, 32'h0, 1'b0);
    // A count write while running lands; the few ticks after it stay small.
    wr(ADDR_CTRL2, 32'(CS_DIV1));
    @(negedge clk);
    chk({31'h0, tick}, 32'h1);
    wr(ADDR_COUNT, 32'h40);
    wr(ADDR_CTRL2, 32'h0);
    rd(ADDR_COUNT, 32'hfc, 32'h40, 1'b0);
    // Clear on compare A keeps the count at or below seven.
    wr(ADDR_CTRL1, 32'h2);
    wr(ADDR_CMP_A, 32'h7);
    wr(ADDR_COUNT, 32'h0);
    run(CS_DIV1, 40);
    rd(ADDR_COUNT, 32'hf8, 32'h0, 1'b0);
    // In a pulse-width mode a compare write waits in the buffer.
    wr(ADDR_CTRL1, 32'h3);
    wr(ADDR_COUNT, 32'h20);
    wr(ADDR_CMP_A, 32'h20);
    @(negedge clk);
    chk({31'h0, match_a}, 32'h0);
    wr(ADDR_CTRL1, 32'h0);
    wr(ADDR_CMP_A, 32'h20);
    @(negedge clk);
    chk({31'h0, match_a}, 32'h1);
    wr(ADDR_CTRL1, 32'h1);
    wr(ADDR_COUNT, 32'hf0);
    run(CS_DIV1, 40);
    chk({31'h0, saw_down}, 32'h1);
    // Prescaler taps: ten periods of each give roughly ten ticks.
    wr(ADDR_CTRL1, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_COUNT, 32'h0);
      run(3'(CS_DIV8 + k), 10 * divs[k]);
      rd(ADDR_COUNT, 32'hf8, 32'h8, 1'b0);
    end
    // External pin: five rising, then five falling edges.
    wr(ADDR_COUNT, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CTRL2, 32'((k == 0) ? CS_EXT_RISE : CS_EXT_FALL));
      repeat (5) begin
        repeat (4) @(posedge clk);
        ext_pin <= 1'b1;
        repeat (4) @(posedge clk);
        ext_pin <= 1'b0;
      end
      repeat (8) @(posedge clk);
      wr(ADDR_CTRL2, 32'h0);
      rd(ADDR_COUNT, 32'hff, 32'(5 * (k + 1)), 1'b0);
    end
    // Reset in mid-run returns the clock select and the count to zero.
    wr(ADDR_CTRL2, 32'(CS_DIV1));
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CTRL2, 32'hffffffff, 32'h0, 1'b0);
    rd(ADDR_COUNT, 32'hffffffff, 32'h0, 1'b0);
    repeat (2) @(posedge clk);
    final_report();
  end
endmodule

`default_nettype wire
